//--- verilog/dtbd_pkg.sv
package dtbd_pkg;
  // ==========================================================
  // instruction fields
  localparam int SRC_LSB   = 5;
  localparam int DST_LSB   = 0;
  localparam int SEL_W     = 5;
  localparam int COND_LSB  = 10;
  localparam int IMM_LSB   = 5;
  localparam int IMM_W     = 24;
  localparam int NA_LSB    = 15;
  localparam int NA_W      = 13;
  localparam int DATA_W    = 32;
  localparam int EXP_W     = 8;
  // ==========================================================
  // selector codes
  localparam logic [4:0] SEL_NONE  = 5'h00;
  localparam logic [4:0] SEL_STK   = 5'h07;
  localparam logic [4:0] SEL_M     = 5'h08;
  localparam logic [4:0] SEL_ML    = 5'h09;
  localparam logic [4:0] SEL_TRE   = 5'h0a;
  localparam logic [4:0] SEL_TR    = 5'h0b;
  localparam logic [4:0] SEL_RP    = 5'h01;
  localparam logic [4:0] SEL_RAM0  = 5'h18;
  localparam logic [4:0] SEL_RAM1  = 5'h19;
  localparam logic [4:0] SEL_BP0   = 5'h1a;
  localparam logic [4:0] SEL_BP1   = 5'h1b;
  localparam logic [4:0] SEL_IX0   = 5'h1c;
  localparam logic [4:0] SEL_IX1   = 5'h1d;
  localparam logic [4:0] SEL_K     = 5'h1e;
  localparam logic [4:0] SEL_L     = 5'h1f;
  localparam logic [31:0] ML_MASK  = 32'h00ffffff;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_STEP  = 13'h0001;

  typedef enum logic [1:0] {DTBD_OP_OTHER, DTBD_OP_LDI, DTBD_OP_BRANCH, DTBD_OP_MOVE} dtbd_op_t;

  typedef struct packed {
    logic        valid;
    dtbd_op_t    op;
    logic [31:0] word;
  } dtbd_instr_t;

  typedef struct packed {
    logic [1:0] zero;
    logic [1:0] carry;
    logic [1:0] sign;
    logic [1:0] ovf;
    logic [1:0] exp_ovf;
    logic       si_full;
    logic       so_empty;
    logic [1:0] in_port;
    logic       ready;
    logic       req_master;
  } dtbd_flags_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [12:0] ret_addr;
  } dtbd_stack_t;
endpackage

//--- verilog/dtbd_decoder.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dtbd_decoder
  import dtbd_pkg::*;
#(
  parameter int GPIO_W = 4
)(
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire dtbd_pkg::dtbd_instr_t      instr,
  input  wire dtbd_pkg::dtbd_flags_t      flags,
  input  wire logic [31:0][31:0]          src_data,
  input  wire logic                       slave_mode,
  input  wire logic [GPIO_W-1:0]          gpio_out_req,
  input  wire logic [GPIO_W-1:0]          gpio_oe_req,
  output logic [31:0]                     bus_data,
  output logic                            bus_valid,
  output logic [31:0]                     wr_en,
  output logic [31:0]                     wr_data,
  output logic                            temp_exponent_part_we,
  output logic [31:0]                     k_data,
  output logic [31:0]                     l_data,
  output logic [12:0]                     next_addr,
  output logic                            ext_fetch,
  output logic                            branch_taken,
  output dtbd_pkg::dtbd_stack_t           stack_op,
  output logic                            local_bus_master,
  output logic [GPIO_W-1:0]               gpio_out,
  output logic [GPIO_W-1:0]               gpio_oe
);
  import dtbd_pkg::*;

  // ==========================================================
  // elaboration checks
  // the i/o pin count is fixed by the device, not a free choice
  if (GPIO_W != 4)
  begin
    $error("gpio width must be four");
  end
  if (SEL_W != 5)
  begin
    $error("selector fields must be five bits wide");
  end
  // the pad in front of the literal assumes these widths fill the word
  if (DATA_W != IMM_W + EXP_W)
  begin
    $error("literal and exponent widths must fill the data word");
  end
  if (DST_LSB + SEL_W > SRC_LSB || SRC_LSB + SEL_W > COND_LSB || COND_LSB + SEL_W > NA_LSB)
  begin
    $error("instruction fields overlap");
  end
  if (NA_LSB + NA_W > DATA_W || IMM_LSB + IMM_W > DATA_W)
  begin
    $error("instruction fields run past the word");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]       bus;
    logic              bus_v;
    logic [31:0]       we;
    logic [31:0]       wdata;
    logic              tre_we;
    logic [31:0]       k;
    logic [31:0]       l;
    logic [12:0]       pc;
    logic              ext;
    logic              taken;
    dtbd_stack_t       stack_top;
    logic [GPIO_W-1:0] gout;
    logic [GPIO_W-1:0] goe;
  } dtbd_state_t;

  dtbd_state_t state_ff;
  dtbd_state_t nxt_state;

  logic [4:0]  src_sel;
  logic [4:0]  dst_sel;
  logic [4:0]  cond_sel;
  logic [23:0] imm;
  logic [12:0] target;

  assign src_sel  = instr.word[SRC_LSB +: SEL_W];
  assign dst_sel  = instr.word[DST_LSB +: SEL_W];
  assign cond_sel = instr.word[COND_LSB +: SEL_W];
  assign imm      = instr.word[IMM_LSB +: IMM_W];
  assign target   = instr.word[NA_LSB +: NA_W];

  // ==========================================================
  // source mux: code indexes the source table directly, except ML, which reads M masked to its low 24 bits
  function automatic logic [31:0] src_value(input logic [4:0] sel);
    logic [31:0] v;
    v = src_data[sel];
    if (sel == SEL_M)
      v = src_data[SEL_M];
    else if (sel == SEL_ML)
      v = src_data[SEL_M] & ML_MASK;
    return v;
  endfunction

  function automatic logic nonzero(input logic [4:0] sel);
    return |src_data[sel];
  endfunction

  // ==========================================================
  // condition test
  function automatic logic cond_met(input logic [4:0] c, input dtbd_flags_t f);
    logic r;
    r = 1'b0;
    unique case (c)
      5'h00: r = 1'b1;
      5'h01: r = 1'b1;
      5'h02: r = 1'b1;
      5'h03: r = nonzero(SEL_RP);
      5'h04: r = f.zero[0];
      5'h05: r = !f.zero[0];
      5'h06: r = f.zero[1];
      5'h07: r = !f.zero[1];
      5'h08: r = f.carry[0];
      5'h09: r = !f.carry[0];
      5'h0a: r = f.carry[1];
      5'h0b: r = !f.carry[1];
      5'h0c: r = f.sign[0];
      5'h0d: r = !f.sign[0];
      5'h0e: r = f.sign[1];
      5'h0f: r = !f.sign[1];
      5'h10: r = f.ovf[0];
      5'h11: r = !f.ovf[0];
      5'h12: r = f.ovf[1];
      5'h13: r = !f.ovf[1];
      5'h14: r = f.exp_ovf[0];
      5'h15: r = f.exp_ovf[1];
      5'h16: r = !f.si_full;
      5'h17: r = !f.so_empty;
      5'h18: r = f.in_port[0];
      5'h19: r = f.in_port[1];
      5'h1a: r = nonzero(SEL_IX0);
      5'h1b: r = nonzero(SEL_IX1);
      5'h1c: r = nonzero(SEL_BP0);
      5'h1d: r = nonzero(SEL_BP1);
      5'h1e: r = f.ready;
      5'h1f: r = f.req_master;
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    logic [31:0] value;
    logic        do_move;
    logic        hit;
    value     = '0;
    do_move   = 1'b0;
    hit       = 1'b0;
    nxt_state = state_ff;
    nxt_state.bus_v  = 1'b0;
    nxt_state.we     = '0;
    nxt_state.tre_we = 1'b0;
    nxt_state.taken  = 1'b0;
    nxt_state.stack_top    = '0;
    // gpio and local bus stay usable whatever the host mode
    nxt_state.gout   = gpio_out_req;
    nxt_state.goe    = gpio_oe_req;

    if (instr.valid)
    begin
      nxt_state.pc = state_ff.pc + PC_STEP;
      if (instr.op == DTBD_OP_LDI)
      begin
        value   = {8'h00, imm};
        do_move = 1'b1;
      end
      else if (instr.op == DTBD_OP_MOVE || instr.op == DTBD_OP_BRANCH)
      begin
        // transfer is independent of the branch outcome
        if (src_sel != SEL_NONE)
        begin
          value           = src_value(src_sel);
          nxt_state.bus   = value;
          nxt_state.bus_v = 1'b1;
          do_move         = 1'b1;
        end
      end

      if (do_move && dst_sel != SEL_NONE)
      begin
        nxt_state.wdata = value;
        unique case (dst_sel)
          SEL_M:
          begin
            nxt_state.we[SEL_L] = 1'b1;
            nxt_state.we[SEL_K] = 1'b1;
            nxt_state.l         = value;
            nxt_state.k         = src_data[SEL_RAM0];
          end
          SEL_ML:
          begin
            nxt_state.we[SEL_K] = 1'b1;
            nxt_state.we[SEL_L] = 1'b1;
            nxt_state.k         = value;
            nxt_state.l         = src_data[SEL_RAM1];
          end
          // only the exponent byte of the temporary register moves
          SEL_TRE: nxt_state.tre_we = 1'b1;
          SEL_K:
          begin
            nxt_state.we[SEL_K] = 1'b1;
            nxt_state.k         = value;
          end
          SEL_L:
          begin
            nxt_state.we[SEL_L] = 1'b1;
            nxt_state.l         = value;
          end
          default: nxt_state.we[dst_sel] = 1'b1;
        endcase
      end

      if (instr.op == DTBD_OP_BRANCH)
      begin
        hit = cond_met(cond_sel, flags);
        nxt_state.taken = hit;
        if (hit)
        begin
          nxt_state.pc = target;
          if (cond_sel == 5'h01)
          begin
            nxt_state.stack_top.push     = 1'b1;
            nxt_state.stack_top.ret_addr = state_ff.pc + PC_STEP;
          end
          else if (cond_sel == 5'h02)
          begin
            nxt_state.stack_top.pop = 1'b1;
            nxt_state.pc      = src_data[SEL_STK][NA_W-1:0];
          end
        end
      end
    end
    nxt_state.ext = nxt_state.pc[NA_W-1];
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_ff    <= '0;
      state_ff.pc <= PC_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  assign bus_data              = state_ff.bus;
  assign bus_valid             = state_ff.bus_v;
  assign wr_en                 = state_ff.we;
  assign wr_data               = state_ff.wdata;
  assign temp_exponent_part_we = state_ff.tre_we;
  assign k_data                = state_ff.k;
  assign l_data                = state_ff.l;
  assign next_addr             = state_ff.pc;
  assign ext_fetch             = state_ff.ext;
  assign branch_taken          = state_ff.taken;
  assign stack_op              = state_ff.stack_top;
  // local bus mastering is kept in both host modes
  assign local_bus_master      = 1'b1;
  assign gpio_out              = state_ff.gout;
  assign gpio_oe               = state_ff.goe;

  logic unused_slave;
  assign unused_slave = slave_mode;
endmodule
`default_nettype wire

//--- sim/dtbd_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dtbd_decoder_sva
  import dtbd_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire dtbd_pkg::dtbd_instr_t instr,
  input wire logic [31:0][31:0]     src_data,
  input wire logic [31:0]           bus_data,
  input wire logic                  bus_valid,
  input wire logic [31:0]           wr_en,
  input wire logic [31:0]           wr_data,
  input wire logic                  temp_exponent_part_we,
  input wire logic [31:0]           k_data,
  input wire logic [31:0]           l_data,
  input wire logic [12:0]           next_addr,
  input wire logic                  ext_fetch,
  input wire logic                  branch_taken,
  input wire dtbd_pkg::dtbd_stack_t stack_op
);
  import dtbd_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // instruction classes
  sequence s_ldi;
    instr.valid && instr.op == DTBD_OP_LDI;
  endsequence
  sequence s_move;
    instr.valid && instr.op == DTBD_OP_MOVE;
  endsequence
  sequence s_branch;
    instr.valid && instr.op == DTBD_OP_BRANCH;
  endsequence
  // ==========================================================
  // transfers
  chk_ldi_literal: assert property (s_ldi and instr.word[4:0] == 5'h10 |=>
    wr_en[16] && wr_data == {8'h00, $past(instr.word[28:5])}) else $error("literal load wrong");
  chk_tre_only: assert property (s_ldi and instr.word[4:0] == SEL_TRE |=>
    temp_exponent_part_we && wr_en == 32'h0) else $error("exponent load wrong");
  chk_src_none: assert property (s_move and instr.word[9:5] == SEL_NONE |=> !bus_valid)
    else $error("bus driven with no source");
  chk_ml_mask: assert property (s_move and instr.word[9:5] == SEL_ML |=>
    bus_data == ($past(src_data[SEL_M]) & ML_MASK)) else $error("low product part wrong");
  chk_lk_pair: assert property (s_move and instr.word[4:0] == SEL_M and instr.word[9:5] != SEL_NONE |=>
    l_data == bus_data && k_data == $past(src_data[24])) else $error("l/k pair load wrong");
  chk_kl_pair: assert property (s_move and instr.word[4:0] == SEL_ML and instr.word[9:5] != SEL_NONE |=>
    k_data == bus_data && l_data == $past(src_data[25])) else $error("k/l pair load wrong");
  // ==========================================================
  // sequencing
  chk_untaken_step: assert property (s_branch ##1 !branch_taken |->
    next_addr == $past(next_addr) + PC_STEP && !stack_op.push && !stack_op.pop)
    else $error("untaken branch misstepped");
  chk_taken_target: assert property ((s_branch and instr.word[14:10] != 5'h02) ##1 branch_taken |->
    next_addr == $past(instr.word[27:15]) && ext_fetch == $past(instr.word[27]))
    else $error("branch target wrong");
  chk_call_push: assert property (s_branch and instr.word[14:10] == 5'h01 |=>
    branch_taken && stack_op.push && stack_op.ret_addr == $past(next_addr) + PC_STEP)
    else $error("call did not push return address");
  chk_xfer_always: assert property (s_branch and instr.word[9:5] != SEL_NONE |=> bus_valid)
    else $error("branch transfer dropped");
endmodule
bind dtbd_decoder dtbd_decoder_sva u_sva (
  .clk_sys(clk_sys), .reset(reset), .instr(instr), .src_data(src_data),
  .bus_data(bus_data), .bus_valid(bus_valid), .wr_en(wr_en), .wr_data(wr_data),
  .temp_exponent_part_we(temp_exponent_part_we), .k_data(k_data), .l_data(l_data),
  .next_addr(next_addr), .ext_fetch(ext_fetch), .branch_taken(branch_taken), .stack_op(stack_op)
);
`default_nettype wire

//--- sim/dtbd_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtbd_seq_model
  import dtbd_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   go,
  input  wire dtbd_pkg::dtbd_op_t     op_in,
  input  wire logic [31:0]            word_in,
  input  wire logic                   zero_regs,
  output var dtbd_pkg::dtbd_instr_t   instr,
  output logic [31:0][31:0]           src_data
);
  import dtbd_pkg::*;
  initial instr = '0;
  // idle word flips every cycle so a stale word is never mistaken for a live one
  always @(posedge clk_sys)
    instr <= go ? {1'b1, op_in, word_in} : {1'b0, DTBD_OP_OTHER, ~instr.word};
  // top byte nonzero unless zero_regs is set, so the low-part mask shows
  always_comb
    for (int i = 0; i < 32; i++)
      src_data[i] = zero_regs ? 32'h0 : {8'h5a ^ 8'(i), 24'h9c3e00 | 24'(i)};
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dtbd_pkg::*;
  logic              clk_sys = 0, reset = 1, go = 0, zero_regs = 0, slave_mode = 1;
  dtbd_op_t          op_in = DTBD_OP_OTHER;
  logic [31:0]       word_in = '0;
  dtbd_flags_t       flags = '0;
  logic [3:0]        gpio_out_req = 4'h0, gpio_oe_req = 4'h0, gpio_out, gpio_oe;
  dtbd_instr_t       instr;
  logic [31:0][31:0] src_data;
  logic [31:0]       bus_data, wr_en, wr_data, k_data, l_data, e;
  logic              bus_valid, te_we, ext_fetch, taken, lbm, tk, inv;
  logic [12:0]       next_addr, pc, pre, tgt;
  dtbd_stack_t       stack_op;
  int                miscompares = 0, checks = 0;

  dtbd_seq_model i_model (.clk_sys(clk_sys), .go(go), .op_in(op_in), .word_in(word_in),
    .zero_regs(zero_regs), .instr(instr), .src_data(src_data));
  dtbd_decoder i_dut (.clk_sys(clk_sys), .reset(reset), .instr(instr), .flags(flags),
    .src_data(src_data), .slave_mode(slave_mode), .gpio_out_req(gpio_out_req),
    .gpio_oe_req(gpio_oe_req), .bus_data(bus_data), .bus_valid(bus_valid), .wr_en(wr_en),
    .wr_data(wr_data), .temp_exponent_part_we(te_we), .k_data(k_data), .l_data(l_data),
    .next_addr(next_addr), .ext_fetch(ext_fetch), .branch_taken(taken), .stack_op(stack_op),
    .local_bus_master(lbm), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one instruction through the sequencer model; results sampled in their one-cycle window
  task automatic exec(dtbd_op_t o, logic [31:0] w);
    @(posedge clk_sys);
    go <= 1'b1;
    op_in <= o;
    word_in <= w;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    pc = pc + PC_STEP;
  endtask

  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    pc = PC_RESET;
    gpio_out_req <= 4'ha;
    gpio_oe_req <= 4'h5;
    exec(DTBD_OP_OTHER, 32'h0);
    cmp("other_pc", pc, next_addr);
    cmp("gpio", 4'ha, gpio_out);
    cmp("gpio_oe", 4'h5, gpio_oe);
    cmp("bus_master", 1, lbm);
    @(posedge clk_sys);
    slave_mode <= 1'b0;
    gpio_out_req <= 4'h3;
    gpio_oe_req <= 4'hc;
    exec(DTBD_OP_OTHER, 32'h0);
    cmp("gpio_master", 4'h3, gpio_out);
    cmp("gpio_oe_master", 4'hc, gpio_oe);
    cmp("bus_master_own", 1, lbm);
    exec(DTBD_OP_LDI, {3'h0, 24'hf1e2d3, 5'h10});
    cmp("ldi_data", 32'h00f1e2d3, wr_data);
    cmp("ldi_en", 32'h1 << 16, wr_en);
    exec(DTBD_OP_LDI, {3'h0, 24'h0000c5, SEL_TRE});
    cmp("tre_we", 1, te_we);
    cmp("tre_en", 0, wr_en);
    cmp("tre_data", 32'hc5, wr_data);
    $display("test load done");
    for (int s = 0; s < 32; s++)
    begin
      exec(DTBD_OP_MOVE, {22'h0, 5'(s), 5'h11});
      e = (s == 9) ? src_data[SEL_M] & ML_MASK : src_data[s];
      cmp("bus_valid", s != 0, bus_valid);
      if (s != 0) cmp("bus_data", e, bus_data);
    end
    $display("test source done");
    for (int d = 0; d < 32; d++)
    begin
      exec(DTBD_OP_MOVE, {22'h0, 5'h12, 5'(d)});
      e = (d == 8 || d == 9) ? 32'hc0000000 : (d == 0 || d == 10) ? 32'h0 : 32'h1 << d;
      cmp("dst_en", e, wr_en);
      cmp("dst_tre", d == 10, te_we);
      if (d == 8) cmp("lk_k", src_data[24], k_data);
      if (d == 8) cmp("lk_l", src_data[18], l_data);
      if (d == 9) cmp("kl_k", src_data[18], k_data);
      if (d == 9) cmp("kl_l", src_data[25], l_data);
    end
    $display("test destination done");
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_sys);
      zero_regs <= (p == 0);
      flags <= {$bits(dtbd_flags_t){p == 1}};
      for (int c = 0; c < 32; c++)
      begin
        pre = pc;
        inv = (c >= 4 && c <= 19 && c % 2 == 1) || c == 22 || c == 23;
        tk = (c < 3) || ((p == 1) ^ inv);
        exec(DTBD_OP_BRANCH, {4'h0, 13'h1abc, 5'(c), 5'h10, 5'h11});
        tgt = (c == 2) ? src_data[7][12:0] : 13'h1abc;
        cmp("taken", tk, taken);
        pc = tk ? tgt : pre + PC_STEP;
        cmp("next", pc, next_addr);
        cmp("ext", pc[12], ext_fetch);
        cmp("push", c == 1, stack_op.push);
        cmp("pop", c == 2, stack_op.pop);
        cmp("xfer", 32'h1 << 17, wr_en);
        if (c == 1) cmp("ret", pre + PC_STEP, stack_op.ret_addr);
      end
    end
    $display("test branch done");
    report_and_stop();
  end
endmodule
`default_nettype wire
